// ---- hw/watchdog_with_shared_prescaler.sv ----
// Watchdog timer with shared 8-bit prescaler and AXI4-Lite registers
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Watchdog counts on free-running oscillator, ignores sleep
// - Expiry forces device reset, also in sleep
// - Expiry reset clears the expiry flag
// - Fuse at zero keeps watchdog off until a system reset samples it high
// - One prescaler, owned by timer or watchdog
// - Owner bit and ratio field in option
// - Unscaled watchdog period is nominally 18 ms
// - Watchdog owner stretches period up to 1:128
// - Kick zeroes counter and owned prescaler
// - Sleep restarts counter and owned prescaler
// - Option loads ones on every reset kind
module watchdog_with_shared_prescaler #(
	parameter int PERIOD_CYC = wdt_pkg::WATCHDOG_PERIOD_CYC
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_watchdog_fuse_enable,
	input  wire logic        i_kick_instruction,
	input  wire logic        i_sleep_instruction,
	input  wire logic        i_core_asleep,
	input  wire logic        i_event_edge,
	output logic             o_event_timer_inc,
	output logic             o_device_rst,
	output logic             o_wake_reset,
	output logic             o_expiry_flag,
	output logic             o_irq,
	input  wire logic [31:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [31:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready
);

	typedef struct packed {
		logic [5:0]               option;
		logic                     fuse;
		logic                     flag;
		logic                     evt_sticky;
		logic                     evt_mask;
		logic [wdt_pkg::BASE_W-1:0] base;
		logic [wdt_pkg::PRE_W-1:0]  pre;
		logic                     evt_inc;
		logic                     dev_rst;
		logic                     wake_rst;
		logic                     irq;
		logic                     aw_have;
		logic [31:0]              aw_addr;
		logic                     w_have;
		logic [31:0]              w_data;
		logic                     w_strb0;
		logic                     awready;
		logic                     wready;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     arready;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
	} state_t;

	state_t q;
	state_t d;

	logic                       owner_wd;
	logic [wdt_pkg::PRE_W-1:0]  ratio_mask;
	logic                       pre_full;
	logic                       base_wrap;
	logic                       expire_w;
	logic                       restart_w;
	logic                       do_wr;
	logic                       wr_hit;

	// Local copy of the time base width, needed before first use
	localparam int BASE_W = wdt_pkg::BASE_W;

	// Prescaler ownership and division mask
	assign owner_wd   = q.option[wdt_pkg::OPT_OWNER_BIT];
	assign ratio_mask = 8'((8'h01 << q.option[wdt_pkg::OPT_RATIO_W-1:0]) - 8'h01);
	assign pre_full   = (q.pre & ratio_mask) == ratio_mask;
	assign base_wrap  = q.base == BASE_W'(PERIOD_CYC - 1);
	// Kick or sleep wins over a coincident expiry
	assign restart_w  = i_kick_instruction | i_sleep_instruction;
	assign expire_w   = q.fuse & base_wrap & (~owner_wd | pre_full) & ~restart_w;
	assign do_wr      = q.aw_have & q.w_have & ~q.bvalid;
	assign wr_hit     = (q.aw_addr == wdt_pkg::OFS_OPTION) | (q.aw_addr == wdt_pkg::OFS_STATUS)
		| (q.aw_addr == wdt_pkg::OFS_MASK) | (q.aw_addr == wdt_pkg::OFS_COUNT);

	// Next-state logic
	always_comb begin
		d         = q;
		d.evt_inc  = 1'b0;
		d.dev_rst  = 1'b0;
		d.wake_rst = 1'b0;

		// Time base runs regardless of core clock state
		if (q.fuse) begin
			if (base_wrap) begin
				d.base = '0;
				if (owner_wd) begin
					d.pre = pre_full ? '0 : 8'(q.pre + 8'h01);
				end
			end else begin
				d.base = BASE_W'(q.base + 1'b1);
			end
		end

		// Event timer side of the shared prescaler
		if (i_event_edge) begin
			if (owner_wd) begin
				d.evt_inc = 1'b1;
			end else if (pre_full) begin
				d.evt_inc = 1'b1;
				d.pre     = '0;
			end else begin
				d.pre = 8'(q.pre + 8'h01);
			end
		end

		// Kick and sleep restart the count
		if (restart_w) begin
			d.base = '0;
			if (owner_wd) begin
				d.pre = '0;
			end
			d.flag = 1'b1;
		end

		// Bus address and data capture
		if (q.awready && i_awvalid) begin
			d.aw_have = 1'b1;
			d.aw_addr = i_awaddr;
		end
		if (q.wready && i_wvalid) begin
			d.w_have  = 1'b1;
			d.w_data  = i_wdata;
			d.w_strb0 = i_wstrb[0];
		end
		if (q.bvalid && i_bready) begin
			d.bvalid = 1'b0;
		end

		// Register write
		if (do_wr) begin
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = wr_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
			if (q.w_strb0) begin
				if (q.aw_addr == wdt_pkg::OFS_OPTION) begin
					d.option = q.w_data[5:0];
					d.pre    = '0;
				end
				if (q.aw_addr == wdt_pkg::OFS_STATUS && q.w_data[wdt_pkg::STAT_EVENT_BIT]) begin
					d.evt_sticky = 1'b0;
				end
				if (q.aw_addr == wdt_pkg::OFS_MASK) begin
					d.evt_mask = q.w_data[wdt_pkg::STAT_EVENT_BIT];
				end
			end
		end

		// Expiry resets the device and the option register
		if (expire_w) begin
			d.dev_rst    = 1'b1;
			d.wake_rst   = i_core_asleep;
			d.flag       = 1'b0;
			d.option     = wdt_pkg::OPTION_RST;
			d.base       = '0;
			d.pre        = '0;
			d.evt_sticky = 1'b1;   // Set wins over clear
		end

		d.awready = ~d.aw_have & ~d.bvalid;
		d.wready  = ~d.w_have & ~d.bvalid;

		// Register read
		if (q.rvalid && i_rready) begin
			d.rvalid = 1'b0;
		end
		if (q.arready && i_arvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = wdt_pkg::RESP_OKAY;
			d.rdata  = 32'h0000_0000;
			case (i_araddr)
				wdt_pkg::OFS_OPTION: d.rdata = {26'h0, q.option};
				wdt_pkg::OFS_STATUS: begin
					d.rdata[wdt_pkg::STAT_EVENT_BIT] = q.evt_sticky;
					d.rdata[wdt_pkg::STAT_FLAG_BIT]  = q.flag;
					d.rdata[wdt_pkg::STAT_FUSE_BIT]  = q.fuse;
				end
				wdt_pkg::OFS_MASK:   d.rdata[wdt_pkg::STAT_EVENT_BIT] = q.evt_mask;
				wdt_pkg::OFS_COUNT:  d.rdata = {3'h0, q.pre, q.base};
				default:             d.rresp = wdt_pkg::RESP_SLVERR;
			endcase
		end
		d.arready = ~d.rvalid;

		d.irq = d.evt_sticky & d.evt_mask;

		// Power-on or external reset; fuse caught here only
		if (i_sys_rst) begin
			d        = '0;
			d.option = wdt_pkg::OPTION_RST;
			d.fuse   = i_watchdog_fuse_enable;
			d.flag   = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		q <= d;
	end

	// Outputs straight from the state register
	assign o_event_timer_inc = q.evt_inc;
	assign o_device_rst      = q.dev_rst;
	assign o_wake_reset      = q.wake_rst;
	assign o_expiry_flag     = q.flag;
	assign o_irq             = q.irq;
	assign o_awready         = q.awready;
	assign o_wready          = q.wready;
	assign o_bresp           = q.bresp;
	assign o_bvalid          = q.bvalid;
	assign o_arready         = q.arready;
	assign o_rdata           = q.rdata;
	assign o_rresp           = q.rresp;
	assign o_rvalid          = q.rvalid;

	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_expire;
		expire_w;
	endsequence

	sequence s_reset_out;
		o_device_rst && !o_expiry_flag && (q.option == wdt_pkg::OPTION_RST);
	endsequence

	property p_expiry_reset;
		s_expire |=> s_reset_out;
	endproperty
	a_expiry_reset: assert property (p_expiry_reset) else $error("expiry gave no reset");

	property p_flag_cleared;
		o_device_rst |-> !o_expiry_flag;
	endproperty
	a_flag_cleared: assert property (p_flag_cleared) else $error("flag set during reset");

	property p_fuse_off;
		!q.fuse |-> !o_device_rst && q.base == '0;
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog acted");

	property p_undivided_event;
		owner_wd && i_event_edge && !expire_w |=> o_event_timer_inc;
	endproperty
	a_undivided_event: assert property (p_undivided_event) else $error("event not passed");

	property p_base_bound;
		q.base < BASE_W'(PERIOD_CYC);
	endproperty
	a_base_bound: assert property (p_base_bound) else $error("base count overran");

	property p_ratio_expiry;
		expire_w |-> base_wrap && (!owner_wd || (q.pre & ratio_mask) == ratio_mask);
	endproperty
	a_ratio_expiry: assert property (p_ratio_expiry) else $error("early expiry");

	property p_kick;
		i_kick_instruction && owner_wd |=> q.base == '0 && q.pre == '0 && !o_device_rst;
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not clear");

	property p_sleep;
		i_sleep_instruction |=> q.base == '0 ##1 !o_device_rst;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep did not restart");

	property p_option_ones;
		o_device_rst |-> q.option == wdt_pkg::OPTION_RST && $past(expire_w);
	endproperty
	a_option_ones: assert property (p_option_ones) else $error("option not reloaded");

	// Further guards on restart, events, fuse and bus hold
	property p_restart_flag;
		restart_w |=> o_expiry_flag;
	endproperty
	a_restart_flag: assert property (p_restart_flag) else $error("flag not set by restart");

	property p_wake_with_reset;
		o_wake_reset |-> o_device_rst;
	endproperty
	a_wake_with_reset: assert property (p_wake_with_reset) else $error("wake reset alone");

	property p_timer_divided;
		!owner_wd && i_event_edge && !pre_full |=> !o_event_timer_inc;
	endproperty
	a_timer_divided: assert property (p_timer_divided) else $error("timer edge not divided");

	property p_restart_blocks;
		restart_w |-> !expire_w;
	endproperty
	a_restart_blocks: assert property (p_restart_blocks) else $error("expiry despite restart");

	property p_fuse_sticks;
		!q.fuse |=> !q.fuse;
	endproperty
	a_fuse_sticks: assert property (p_fuse_sticks) else $error("fuse re-enabled");

	property p_irq_level;
		o_irq == (q.evt_sticky & q.evt_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	property p_bvalid_hold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

	property p_rvalid_hold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

endmodule // watchdog_with_shared_prescaler

// ---- hw/wdt_pkg.sv ----
// Constants and register map of the watchdog block
package wdt_pkg;
	// Register byte offsets
	localparam logic [31:0] OFS_OPTION     = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS     = 32'h0000_0004;
	localparam logic [31:0] OFS_MASK       = 32'h0000_0008;
	localparam logic [31:0] OFS_COUNT      = 32'h0000_000C;
	// Option register layout and reset value
	localparam logic [5:0]  OPTION_RST     = 6'h3F;
	localparam int          OPT_OWNER_BIT  = 3;
	localparam int          OPT_RATIO_LSB  = 0;
	localparam int          OPT_RATIO_W    = 3;
	// Status register bit positions
	localparam int          STAT_EVENT_BIT = 0;
	localparam int          STAT_FLAG_BIT  = 4;
	localparam int          STAT_FUSE_BIT  = 8;
	// Timing
	localparam longint      WATCHDOG_NOMINAL_NS = 18_000_000;
	localparam longint      CLK_PERIOD_NS       = 10;
	localparam int          WATCHDOG_PERIOD_CYC = int'(WATCHDOG_NOMINAL_NS / CLK_PERIOD_NS);
	localparam int          BASE_W         = 21;
	localparam int          PRE_W          = 8;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ---- verification/watchdog_with_shared_prescaler_tb.sv ----
// Self-checking bench for the watchdog block over its register bus
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin check_count++; if ((act) !== (exp)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, msg); end end
module watchdog_with_shared_prescaler_tb;
	localparam int P = 16;
	logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, fuse = 1'b1, kick = 1'b0, sleep_i = 1'b0, asleep = 1'b0, edge_i = 1'b0;
	logic o_event_timer_inc, o_device_rst, o_wake_reset, o_expiry_flag, o_irq;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, o_rdata, rd;
	logic [1:0]  o_bresp, o_rresp, rsp;
	int          miscompares = 0, check_count = 0, n_rst = 0, n_inc = 0, n, k;
	// Clock and event counters
	always #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		if (o_device_rst === 1'b1) n_rst++;
		if (o_event_timer_inc === 1'b1) n_inc++;
	end
	watchdog_with_shared_prescaler #(.PERIOD_CYC(P)) u_watchdog_with_shared_prescaler (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_watchdog_fuse_enable(fuse), .i_kick_instruction(kick),
		.i_sleep_instruction(sleep_i), .i_core_asleep(asleep), .i_event_edge(edge_i),
		.o_event_timer_inc(o_event_timer_inc), .o_device_rst(o_device_rst), .o_wake_reset(o_wake_reset),
		.o_expiry_flag(o_expiry_flag), .o_irq(o_irq), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready),
		.i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
		.o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready));
	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bit ad, dd;
		@(posedge i_ref_clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		ad = 0; dd = 0;
		while (!(ad && dd)) begin
			@(posedge i_ref_clk);
			if (awvalid && o_awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
			if (wvalid && o_wready === 1'b1) begin dd = 1; wvalid <= 1'b0; end
		end
		do @(posedge i_ref_clk); while (o_bvalid !== 1'b1);
		rsp = o_bresp; bready <= 1'b0;
	endtask
	// Bus read: result left in rd and rsp
	task automatic rdr(input logic [31:0] a);
		@(posedge i_ref_clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge i_ref_clk); while (o_arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
		rd = o_rdata; rsp = o_rresp; rready <= 1'b0;
	endtask
	// Reset for six cycles with a given fuse setting
	task automatic do_reset(input logic f);
		@(posedge i_ref_clk);
		i_sys_rst <= 1'b1; fuse <= f;
		repeat (6) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
	endtask
	// Kick or sleep, then count cycles to the expiry reset
	task automatic expire(input bit slp, input int e, input string m);
		@(posedge i_ref_clk);
		if (slp) sleep_i <= 1'b1; else kick <= 1'b1;
		@(posedge i_ref_clk);
		sleep_i <= 1'b0; kick <= 1'b0; n = 0;
		while (o_device_rst !== 1'b1 && n < 5000) begin @(posedge i_ref_clk); n++; end
		`CHK(n >= e - 1 && n <= e + 3, 1'b1, m)
		`CHK(o_wake_reset, asleep, "wake reset qualifier")
		@(posedge i_ref_clk);
		`CHK(o_expiry_flag, 1'b0, "flag after expiry")
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		#500_000;
		miscompares++;
		$display("CHECK FAILED %0t bench timeout", $time);
		end_sim();
	end
	initial begin
		do_reset(1'b1);
		// Reset values and unmapped addresses
		rdr(wdt_pkg::OFS_OPTION); `CHK(rd, 32'h0000_003F, "option reset value")
		rdr(wdt_pkg::OFS_STATUS); `CHK(rd[8:4], 5'h11, "fuse and flag at reset")
		rdr(32'h0000_0040); `CHK(rsp, wdt_pkg::RESP_SLVERR, "unmapped read")
		wr(32'h0000_0040, 32'h0); `CHK(rsp, wdt_pkg::RESP_SLVERR, "unmapped write")
		$display("test reset_values done");
		// Every ratio with watchdog ownership, option reloads ones after expiry
		for (k = 0; k < 8; k++) begin
			kick <= 1'b1; // Hold off expiry until the measured kick
			wr(wdt_pkg::OFS_OPTION, 32'h0000_00C8 | k); `CHK(rsp, wdt_pkg::RESP_OKAY, "option write")
			rdr(wdt_pkg::OFS_OPTION); `CHK(rd, 32'h0000_0008 | k, "option readback")
			expire(1'b0, P << k, "watchdog period with ratio");
			rdr(wdt_pkg::OFS_OPTION); `CHK(rd[7:0], 8'h3F, "option after expiry")
		end
		kick <= 1'b1; wr(wdt_pkg::OFS_OPTION, 32'h0000_0005);
		expire(1'b0, P, "timer owner leaves watchdog undivided");
		$display("test periods done");
		// Interrupt raised, masked and cleared
		rdr(wdt_pkg::OFS_STATUS); `CHK(rd[4:0], 5'h01, "event sticky, flag low")
		`CHK(o_irq, 1'b0, "irq masked")
		wr(wdt_pkg::OFS_MASK, 32'h1); repeat (2) @(posedge i_ref_clk); `CHK(o_irq, 1'b1, "irq unmasked")
		wr(wdt_pkg::OFS_OPTION, 32'h0000_000F); wr(wdt_pkg::OFS_STATUS, 32'h1);
		repeat (2) @(posedge i_ref_clk); `CHK(o_irq, 1'b0, "irq cleared")
		wr(wdt_pkg::OFS_MASK, 32'h0);
		$display("test interrupt done");
		// Regular kicks hold off expiry
		kick <= 1'b1; wr(wdt_pkg::OFS_OPTION, 32'h0000_0008); k = n_rst;
		repeat (20) begin
			@(posedge i_ref_clk); kick <= 1'b1; @(posedge i_ref_clk); kick <= 1'b0;
			repeat (P / 2) @(posedge i_ref_clk);
		end
		`CHK(n_rst, k, "kicked watchdog stays quiet")
		`CHK(o_expiry_flag, 1'b1, "flag set by kick")
		$display("test kick done");
		// Sleep restarts the count and gives a wake-up reset
		asleep <= 1'b1; wr(wdt_pkg::OFS_OPTION, 32'h0000_000A);
		expire(1'b1, P << 2, "sleep period");
		asleep <= 1'b0;
		$display("test sleep done");
		// Prescaler on event timer divides edges, on watchdog passes each edge
		kick <= 1'b1; wr(wdt_pkg::OFS_OPTION, 32'h0000_0002); k = n_inc;
		repeat (8) begin
			@(posedge i_ref_clk); edge_i <= 1'b1; kick <= 1'b1;
			@(posedge i_ref_clk); edge_i <= 1'b0; kick <= 1'b0;
		end
		repeat (3) @(posedge i_ref_clk); `CHK(n_inc - k, 2, "timer prescaled edges")
		wr(wdt_pkg::OFS_OPTION, 32'h0000_000F); k = n_inc;
		repeat (4) begin
			@(posedge i_ref_clk); edge_i <= 1'b1; @(posedge i_ref_clk); edge_i <= 1'b0;
		end
		repeat (3) @(posedge i_ref_clk); `CHK(n_inc - k, 4, "undivided timer edges")
		$display("test event_timer done");
		// Fuse at zero keeps the watchdog off
		do_reset(1'b0); k = n_rst;
		wr(wdt_pkg::OFS_OPTION, 32'h0000_0008);
		repeat (10 * P) @(posedge i_ref_clk);
		`CHK(n_rst, k, "fuse off, no expiry")
		rdr(wdt_pkg::OFS_STATUS); `CHK(rd[8], 1'b0, "fuse bit reads zero")
		$display("test fuse_off done");
		end_sim();
	end
endmodule // watchdog_with_shared_prescaler_tb
